/* File: hdl/lan_ctrl_command_status.sv */
// Main command/status register with its indirect select and data ports.
module lan_ctrl_command_status
  import lan_ctrl_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = lan_ctrl_pkg::BUS_TIMEOUT_CYCLES
) (
  input  wire logic                            i_sys_clk,
  input  wire logic                            i_reset,
  input  wire logic                            i_clk_en,
  input  wire logic                            i_port_sel,
  input  wire logic                            i_wr_en,
  input  wire logic                            i_rd_en,
  input  wire logic [lan_ctrl_pkg::DATA_W-1:0] i_wdata,
  output logic      [lan_ctrl_pkg::DATA_W-1:0] o_rdata,
  output logic                                 o_ack,
  input  wire logic                            i_rx_ring_done,
  input  wire logic                            i_tx_ring_done,
  input  wire logic                            i_setup_read_done,
  input  wire logic                            i_receiver_disable_option,
  input  wire logic                            i_transmitter_disable_option,
  input  wire logic                            i_tx_error,
  input  wire logic                            i_babble_error,
  input  wire logic                            i_lost_frame_error,
  input  wire logic                            i_master_addr_valid,
  input  wire logic                            i_master_ready,
  input  wire logic                            i_tx_poll_taken,
  output logic                                 o_setup_fetch,
  output logic                                 o_run_enable,
  output logic                                 o_tx_poll_request,
  output logic                                 o_receiver_active,
  output logic                                 o_transmitter_active,
  output logic                                 o_halted,
  output logic                                 o_irq_n
);

  import lan_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Host port decode.
  ctrl_state_type       state;
  ctrl_state_type       next_state;
  logic [1:0]           select_index;
  logic                 halt;
  logic                 run_control;
  logic                 setup_request;
  logic                 transmit_poll_request;
  logic                 irq_pin_enable;
  logic                 receiver_active;
  logic                 transmitter_active;
  logic                 params_read;
  logic                 setup_issued;
  logic                 rx_disable_seen;
  logic                 tx_disable_seen;
  logic [NUM_FLAGS-1:0] flags;
  logic                 bus_timeout;

  // Other select values name registers outside this block; they answer only while halted.
  wire sel_main    = (select_index == SEL_MAIN);
  wire data_access = !i_port_sel && (i_wr_en || i_rd_en);
  wire responds    = i_port_sel || sel_main || halt;
  wire main_wr     = i_wr_en && !i_port_sel && sel_main;

  // A write that carries halt ignores the run, setup and other bits.
  wire w_halt  = main_wr && i_wdata[BIT_HALT]; // RULE17
  wire w_run   = main_wr && i_wdata[BIT_RUN] && !i_wdata[BIT_HALT]; // RULE16
  wire w_setup = main_wr && i_wdata[BIT_SETUP] && !i_wdata[BIT_HALT]; // RULE16
  wire w_poll  = main_wr && i_wdata[BIT_POLL] && !i_wdata[BIT_HALT];
  wire w_ien   = main_wr && !i_wdata[BIT_HALT];
  wire active  = !halt;

  assign o_ack = (i_port_sel && (i_wr_en || i_rd_en)) || (data_access && responds);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing of halt, setup and run.
  wire setup_done   = (state == ST_SETTING) && i_setup_read_done && !w_halt; // RULE4
  wire enter_setup  = w_setup && (state != ST_SETTING); // RULE20
  wire run_pending  = run_control || w_run;
  // Run that arrives with or during setup waits for the parameter block.
  wire start_direct = w_run && !w_setup && (state == ST_OPERATING || state == ST_HALTED);
  wire start_now    = start_direct || (setup_done && run_pending); // RULE19
  wire rx_ok        = setup_done ? !i_receiver_disable_option : (params_read && !rx_disable_seen);
  wire tx_ok        = setup_done ? !i_transmitter_disable_option
                                 : ((setup_issued || w_setup) && !tx_disable_seen);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_HALTED: begin
        if (w_setup) begin
          next_state = ST_SETTING;
        end else if (w_run) begin
          next_state = ST_OPERATING; // RULE15
        end
      end
      ST_SETTING: begin
        if (w_halt) begin
          next_state = ST_HALTED;
        end else if (i_setup_read_done) begin
          next_state = ST_OPERATING;
        end
      end
      ST_OPERATING: begin
        if (w_halt) begin
          next_state = ST_HALTED;
        end else if (w_setup) begin
          next_state = ST_SETTING;
        end
      end
      default: next_state = ST_HALTED;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state         <= ST_HALTED;
      halt          <= HALT_RESET; // RULE17
      select_index  <= SEL_RESET;
      o_setup_fetch <= 1'b0;
    end else if (i_clk_en) begin
      state         <= next_state;
      o_setup_fetch <= enter_setup; // RULE20
      if (i_wr_en && i_port_sel) begin
        select_index <= i_wdata[1:0];
      end
      if (w_halt) begin
        halt <= 1'b1; // RULE15
      end else if (w_run || w_setup) begin
        halt <= 1'b0; // RULE15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command bits and indicators; a halt write clears them all as reset does.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      run_control   <= 1'b0;
      setup_request <= 1'b0;
      setup_issued  <= 1'b0;
      params_read   <= 1'b0;
    end else if (i_clk_en) begin
      if (w_halt) begin
        run_control   <= 1'b0; // RULE21
        setup_request <= 1'b0; // RULE21
        setup_issued  <= 1'b0;
        params_read   <= 1'b0;
      end else begin
        run_control   <= run_control || w_run; // RULE21
        setup_request <= setup_request || w_setup; // RULE21
        setup_issued  <= setup_issued || w_setup;
        params_read   <= (params_read && !enter_setup) || setup_done;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_disable_seen <= 1'b0;
      tx_disable_seen <= 1'b0;
    end else if (i_clk_en) begin
      if (w_halt) begin
        rx_disable_seen <= 1'b0;
        tx_disable_seen <= 1'b0;
      end else if (setup_done) begin
        rx_disable_seen <= i_receiver_disable_option;
        tx_disable_seen <= i_transmitter_disable_option;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      receiver_active <= 1'b0;
    end else if (i_clk_en) begin
      if (w_halt || bus_timeout) begin
        receiver_active <= 1'b0; // RULE12
      end else if (setup_done && i_receiver_disable_option) begin
        receiver_active <= 1'b0; // RULE9
      end else if (start_now && rx_ok) begin
        receiver_active <= 1'b1; // RULE8
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      transmitter_active <= 1'b0;
    end else if (i_clk_en) begin
      if (w_halt || bus_timeout || (i_tx_error && active)) begin
        transmitter_active <= 1'b0; // RULE11
      end else if (setup_done && i_transmitter_disable_option) begin
        transmitter_active <= 1'b0; // RULE11
      end else if (start_now && tx_ok) begin
        transmitter_active <= 1'b1; // RULE10
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      transmit_poll_request <= 1'b0;
      irq_pin_enable        <= 1'b0;
    end else if (i_clk_en) begin
      if (w_halt) begin
        transmit_poll_request <= 1'b0; // RULE14
        irq_pin_enable        <= 1'b0; // RULE7
      end else begin
        transmit_poll_request <= w_poll || (transmit_poll_request && !i_tx_poll_taken); // RULE14
        if (w_ien) begin
          irq_pin_enable <= i_wdata[BIT_IRQ_EN]; // RULE7
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event flags, bus watchdog and interrupt pin.
  wire [NUM_FLAGS-1:0] flag_set;
  wire [NUM_FLAGS-1:0] flag_w1c;
  assign flag_set[FLAG_RX_RING]    = i_rx_ring_done && active; // RULE1
  assign flag_set[FLAG_TX_RING]    = i_tx_ring_done && active; // RULE2
  assign flag_set[FLAG_SETUP_DONE] = setup_done; // RULE4
  assign flag_set[FLAG_TIMEOUT]    = bus_timeout; // RULE22
  assign flag_w1c[FLAG_RX_RING]    = main_wr && i_wdata[BIT_RX_RING]; // RULE3
  assign flag_w1c[FLAG_TX_RING]    = main_wr && i_wdata[BIT_TX_RING]; // RULE3
  assign flag_w1c[FLAG_SETUP_DONE] = main_wr && i_wdata[BIT_SETUP_DONE]; // RULE3
  assign flag_w1c[FLAG_TIMEOUT]    = main_wr && i_wdata[BIT_BUS_TIMEOUT];
  event_flag_bank u_flags (
    .i_sys_clk         (i_sys_clk),
    .i_reset           (i_reset),
    .i_clk_en          (i_clk_en),
    .i_clear_all       (w_halt),
    .i_set             (flag_set),
    .i_write_one_clear (flag_w1c),
    .o_flags           (flags)
  );

  bus_ready_watchdog #(
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
  ) u_watchdog (
    .i_sys_clk    (i_sys_clk),
    .i_reset      (i_reset),
    .i_clk_en     (i_clk_en),
    .i_abort      (halt || w_halt),
    .i_addr_valid (i_master_addr_valid),
    .i_ready      (i_master_ready),
    .o_timeout    (bus_timeout)
  );

  wire error_any = i_babble_error || i_lost_frame_error || flags[FLAG_TIMEOUT];
  wire interrupt_summary = error_any || flags[FLAG_RX_RING] || flags[FLAG_TX_RING]
                           || flags[FLAG_SETUP_DONE]; // RULE5

  // The pin mixes registered state with the live babble and lost-frame inputs; a bus write reaches it only through registers.
  assign o_irq_n = !(irq_pin_enable && interrupt_summary); // RULE6

  assign o_run_enable         = run_control && (state == ST_OPERATING); // RULE18
  assign o_tx_poll_request    = transmit_poll_request; // RULE13
  assign o_receiver_active    = receiver_active;
  assign o_transmitter_active = transmitter_active;
  assign o_halted             = halt;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path.
  wire [DATA_W-1:0] main_word;
  wire [DATA_W-1:0] read_word;
  assign main_word[BIT_SETUP]       = setup_request;
  assign main_word[BIT_RUN]         = run_control;
  assign main_word[BIT_HALT]        = halt;
  assign main_word[BIT_POLL]        = transmit_poll_request;
  assign main_word[BIT_TX_ACTIVE]   = transmitter_active;
  assign main_word[BIT_RX_ACTIVE]   = receiver_active;
  assign main_word[BIT_IRQ_EN]      = irq_pin_enable;
  assign main_word[BIT_SUMMARY]     = interrupt_summary;
  assign main_word[BIT_SETUP_DONE]  = flags[FLAG_SETUP_DONE];
  assign main_word[BIT_TX_RING]     = flags[FLAG_TX_RING];
  assign main_word[BIT_RX_RING]     = flags[FLAG_RX_RING];
  assign main_word[BIT_BUS_TIMEOUT] = flags[FLAG_TIMEOUT];
  assign main_word[BIT_LOST_FRAME]  = i_lost_frame_error;
  assign main_word[BIT_RSVD]        = 1'b0;
  assign main_word[BIT_BABBLE]      = i_babble_error;
  assign main_word[BIT_ERR_SUMMARY] = error_any;

  assign read_word = i_port_sel ? {{(DATA_W-2){1'b0}}, select_index}
                   : (sel_main ? main_word : '0);
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else if (i_clk_en && i_rd_en && (i_port_sel || responds)) begin
      o_rdata <= read_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  halt_priority_a: assert property ( // RULE16
    i_clk_en && w_halt |=> halt && !run_control && !setup_request && state == ST_HALTED)
    else $error("halt write did not override run and setup");
  halt_hold_a: assert property ( // RULE15
    halt && i_clk_en && !w_run && !w_setup |=> halt)
    else $error("halt released without run or setup");
  flag_keep_a: assert property ( // RULE3
    i_clk_en && !w_halt && flags[FLAG_RX_RING] && !flag_w1c[FLAG_RX_RING] |=> flags[FLAG_RX_RING])
    else $error("receive-ring flag lost without write of one");
  set_wins_a: assert property ( // RULE23
    i_clk_en && !w_halt && flag_set[FLAG_TX_RING] && flag_w1c[FLAG_TX_RING]
      |=> flags[FLAG_TX_RING])
    else $error("transmit-ring event lost to a clear");
  setup_flag_a: assert property ( // RULE4
    i_clk_en && setup_done |=> flags[FLAG_SETUP_DONE] && state == ST_OPERATING)
    else $error("setup completion not flagged");
  irq_pin_a: assert property ( // RULE6
    o_irq_n == !(irq_pin_enable && ((|flags) || i_babble_error || i_lost_frame_error)))
    else $error("interrupt pin does not follow enable and summary");
  timeout_off_a: assert property ( // RULE22
    i_clk_en && bus_timeout && !w_halt
      |=> !receiver_active && !transmitter_active && flags[FLAG_TIMEOUT])
    else $error("bus timeout left receiver or transmitter on");
  run_waits_a: assert property ( // RULE19
    state == ST_SETTING |-> !o_run_enable && !$rose(receiver_active))
    else $error("run operation began before setup finished");
  poll_taken_a: assert property ( // RULE14
    i_clk_en && transmit_poll_request && i_tx_poll_taken && !w_poll ##1 !i_wr_en [*2]
      |-> !transmit_poll_request)
    else $error("poll request not cleared once taken");
  halt_clears_a: assert property ( // RULE12
    i_clk_en && w_halt |=> !receiver_active && !transmitter_active && !irq_pin_enable
      && (!interrupt_summary || i_babble_error || i_lost_frame_error))
    else $error("halt did not clear indicators");

  setup_then_run_c: cover property (
    i_clk_en && w_setup && w_run ##[1:50] receiver_active && transmitter_active);
  flag_irq_c: cover property (flags[FLAG_RX_RING] && irq_pin_enable ##1 !o_irq_n);
  timeout_c: cover property (bus_timeout);
  all_three_c: cover property (i_clk_en && w_halt && i_wdata[BIT_RUN] && i_wdata[BIT_SETUP]);

endmodule

/* File: include/lan_ctrl_pkg.sv */
// Constants and types shared by the LAN controller command/status logic.
// Overview of operation
// RULE1 - Receive-ring flag bit 10 sets whenever a receive descriptor entry is updated.
// RULE2 - Transmit-ring flag bit 9 sets whenever a transmit descriptor entry is updated.
// RULE3 - Event flags clear only by writing 1, reset or halt; written 0 ignored.
// RULE4 - Setup-complete flag bit 8 sets once the parameter block is read and stored.
// RULE5 - Summary flag ORs all event and error flags; read-only, cleared by reset/halt; stays set here while babble or lost-frame input is high.
// RULE6 - Interrupt pin low only when pin enable bit 6 and summary are both 1.
// RULE7 - Interrupt pin enable is plain read/write, cleared by reset and halt.
// RULE8 - Receiver-active bit 5 sets on run if parameters read and receive not disabled.
// RULE9 - Receiver-active clears on setup done with receive disabled, or bus timeout.
// RULE10 - Transmitter-active sets on run if setup issued and transmit not disabled.
// RULE11 - Transmitter-active clears on setup with transmit disabled, transmit error, bus timeout.
// RULE12 - Both active bits are read-only and cleared by reset and halt.
// RULE13 - Transmit-poll bit 3 makes the device scan the transmit ring at once.
// RULE14 - Poll bit set by writing 1, cleared when taken, by reset or halt.
// RULE15 - Halt bit 2 stops all activity, clears logic, holds until run or setup.
// RULE16 - Run, setup and halt written together: only halt takes effect.
// RULE17 - Halt set by reset or by writing 1; writing 0 does nothing.
// RULE18 - Run bit 1 enables frames, bus-master transfers and descriptor management.
// RULE19 - Run and setup written together: setup finishes before run operation starts.
// RULE20 - Setup bit 0 starts fetching the parameter block from memory.
// RULE21 - Run and setup bits set only by writing 1, cleared by reset or halt.
// RULE22 - No bus ready within 25.6 us of an address switches receiver and transmitter off.
// RULE23 - A hardware set and a write-1 clear in one cycle: the set wins.
package lan_ctrl_pkg;

  localparam int DATA_W = 16;

  // Values of the select port that address the register behind the data port.
  localparam logic [1:0] SEL_MAIN   = 2'h0;
  localparam logic [1:0] SEL_RESET  = 2'h0;

  // Field positions of the main command/status register.
  localparam int BIT_SETUP       = 0;
  localparam int BIT_RUN         = 1;
  localparam int BIT_HALT        = 2;
  localparam int BIT_POLL        = 3;
  localparam int BIT_TX_ACTIVE   = 4;
  localparam int BIT_RX_ACTIVE   = 5;
  localparam int BIT_IRQ_EN      = 6;
  localparam int BIT_SUMMARY     = 7;
  localparam int BIT_SETUP_DONE  = 8;
  localparam int BIT_TX_RING     = 9;
  localparam int BIT_RX_RING     = 10;
  localparam int BIT_BUS_TIMEOUT = 11;
  localparam int BIT_LOST_FRAME  = 12;
  localparam int BIT_RSVD        = 13;
  localparam int BIT_BABBLE      = 14;
  localparam int BIT_ERR_SUMMARY = 15;

  // Index of each sticky flag inside the flag bank.
  localparam int NUM_FLAGS       = 4;
  localparam int FLAG_RX_RING    = 0;
  localparam int FLAG_TX_RING    = 1;
  localparam int FLAG_SETUP_DONE = 2;
  localparam int FLAG_TIMEOUT    = 3;

  localparam logic HALT_RESET = 1'b1;

  // Bus-master ready timeout.
  localparam int CLK_PERIOD_PS      = 4000;
  localparam int BUS_TIMEOUT_NS     = 25600;
  localparam int BUS_TIMEOUT_CYCLES = (BUS_TIMEOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    ST_HALTED    = 3'b001,
    ST_SETTING   = 3'b010,
    ST_OPERATING = 3'b100
  } ctrl_state_type;

endpackage

/* File: hdl/event_flag_bank.sv */
// Sticky event flags, set by hardware and cleared by writing 1.
module event_flag_bank
  import lan_ctrl_pkg::*;
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_clk_en,
  input  wire logic                 i_clear_all,
  input  wire logic [NUM_FLAGS-1:0] i_set,
  input  wire logic [NUM_FLAGS-1:0] i_write_one_clear,
  output logic      [NUM_FLAGS-1:0] o_flags
);

  genvar g;
  generate
    for (g = 0; g < NUM_FLAGS; g++) begin : gen_flag
      always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
          o_flags[g] <= 1'b0;
        end else if (i_clk_en) begin
          // A set in the clearing cycle survives; halt clears unconditionally.
          if (i_clear_all) begin
            o_flags[g] <= 1'b0; // RULE3
          end else if (i_set[g]) begin
            o_flags[g] <= 1'b1; // RULE23
          end else if (i_write_one_clear[g]) begin
            o_flags[g] <= 1'b0; // RULE3
          end
        end
      end
    end
  endgenerate

endmodule

/* File: hdl/bus_ready_watchdog.sv */
// Watchdog that flags a bus-master cycle left without a ready answer.
module bus_ready_watchdog #(
  parameter int TIMEOUT_CYCLES = 6400
) (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_clk_en,
  input  wire logic i_abort,
  input  wire logic i_addr_valid,
  input  wire logic i_ready,
  output logic      o_timeout
);

  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYCLES - 1);

  logic          waiting;
  logic [CW-1:0] count;
  wire           expire = waiting && (count == LAST) && !i_ready;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      waiting   <= 1'b0;
      count     <= '0;
      o_timeout <= 1'b0;
    end else if (i_clk_en) begin
      o_timeout <= expire && !i_abort; // RULE22
      if (i_abort || i_ready || expire) begin
        waiting <= 1'b0;
        count   <= '0;
      end else if (waiting) begin
        count <= count + 1'b1;
      end else if (i_addr_valid) begin
        waiting <= 1'b1;
        count   <= '0;
      end
    end
  end

endmodule

/* File: sim/host_model.sv */
// Host model that reaches the command/status register through the select and data ports.
module host_model (
  input  wire logic        i_sys_clk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_ack,
  output logic             o_port_sel,
  output logic             o_wr_en,
  output logic             o_rd_en,
  output logic      [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ack_seen;
  initial begin
    o_port_sel = 1'b0;
    o_wr_en    = 1'b0;
    o_rd_en    = 1'b0;
    o_wdata    = 16'h0000;
    ack_seen   = 1'b0;
  end
  // Released data is inverted so a stale value can never be mistaken for a fresh write.
  task automatic wr(input logic sel, input logic [15:0] d);
    @(negedge i_sys_clk);
    o_port_sel = sel;
    o_wdata    = d;
    o_wr_en    = 1'b1;
    @(posedge i_sys_clk);
    ack_seen = i_ack;
    @(negedge i_sys_clk);
    o_wr_en = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic rd(output logic [15:0] d);
    @(negedge i_sys_clk);
    o_port_sel = 1'b0;
    o_rd_en    = 1'b1;
    @(posedge i_sys_clk);
    ack_seen = i_ack;
    @(negedge i_sys_clk);
    o_rd_en = 1'b0;
    d       = i_rdata;
  endtask
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the command/status register block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lan_ctrl_pkg::*;
  localparam int TO = 16;
  logic clk, rst, psel, wen, ren, ack, fetch, run_en, poll, rxa, txa, halted, irq_n;
  logic rx_done, tx_done, su_done, rx_dis, tx_dis, tx_err, addr_v, taken, ready, babble, lost;
  logic [15:0] wdata, rdata, rd;
  int mismatches, n_tests, cycles;

  lan_ctrl_command_status #(.TIMEOUT_CYCLES(TO)) dut (
    .i_sys_clk(clk), .i_reset(rst), .i_clk_en(1'b1), .i_port_sel(psel), .i_wr_en(wen),
    .i_rd_en(ren), .i_wdata(wdata), .o_rdata(rdata), .o_ack(ack),
    .i_rx_ring_done(rx_done), .i_tx_ring_done(tx_done), .i_setup_read_done(su_done),
    .i_receiver_disable_option(rx_dis), .i_transmitter_disable_option(tx_dis),
    .i_tx_error(tx_err), .i_babble_error(babble), .i_lost_frame_error(lost),
    .i_master_addr_valid(addr_v), .i_master_ready(ready), .i_tx_poll_taken(taken),
    .o_setup_fetch(fetch), .o_run_enable(run_en), .o_tx_poll_request(poll),
    .o_receiver_active(rxa), .o_transmitter_active(txa), .o_halted(halted), .o_irq_n(irq_n));

  host_model host (.i_sys_clk(clk), .i_rdata(rdata), .i_ack(ack), .o_port_sel(psel),
    .o_wr_en(wen), .o_rd_en(ren), .o_wdata(wdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // The setup bit is masked because whether it stays set after setup is left open.
  task automatic rdchk(input logic [15:0] exp);
    host.rd(rd);
    chk(rd & 16'hfffe, exp);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic summarize;
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_setup_run;
    logic seen;
    seen = 1'b0;
    host.wr(1'b0, 16'h0043);
    repeat (2) begin
      if (fetch === 1'b1) seen = 1'b1;
      @(negedge clk);
    end
    chk(seen, 1'b1);
    pulse(su_done);
    rdchk(16'h01f2);
    chk(host.ack_seen, 1'b1);
    chk({run_en, rxa, txa, irq_n}, 4'he);
  endtask
  task automatic s_events;
    pulse(rx_done);
    pulse(tx_done);
    rdchk(16'h07f2);
    host.wr(1'b0, 16'h0040);
    rdchk(16'h07f2);
    host.wr(1'b0, 16'h0440);
    rdchk(16'h03f2);
    fork
      host.wr(1'b0, 16'h0240);
      pulse(tx_done);
    join
    rdchk(16'h03f2);
    host.wr(1'b0, 16'h0340);
    rdchk(16'h0072);
    chk(irq_n, 1'b1);
  endtask
  task automatic s_poll;
    host.wr(1'b0, 16'h0048);
    @(negedge clk);
    chk(poll, 1'b1);
    pulse(taken);
    @(negedge clk);
    chk(poll, 1'b0);
    host.wr(1'b0, 16'h0040);
    chk(poll, 1'b0);
  endtask
  // A ready answer well inside the window must keep the watchdog quiet.
  task automatic s_ready;
    pulse(addr_v);
    repeat (3) @(negedge clk);
    pulse(ready);
    repeat (TO + 4) @(negedge clk);
    chk({rxa, txa, irq_n}, 3'h7);
    babble = 1'b1;
    rdchk(16'hc0f2);
    chk(irq_n, 1'b0);
    babble = 1'b0;
    lost   = 1'b1;
    rdchk(16'h90f2);
    lost   = 1'b0;
  endtask
  task automatic s_timeout;
    pulse(addr_v);
    repeat (TO + 4) @(negedge clk);
    chk({rxa, txa, irq_n}, 3'h0);
    rdchk(16'h88c2);
    host.wr(1'b0, 16'h0000);
    chk(irq_n, 1'b1);
  endtask
  task automatic s_halt;
    host.wr(1'b0, 16'h0047);
    rdchk(16'h0004);
    chk({halted, irq_n}, 2'h3);
    host.wr(1'b0, 16'h0000);
    pulse(rx_done);
    rdchk(16'h0004);
  endtask
  task automatic setup_once(input logic [15:0] w, input logic rd_off, input logic td_off);
    host.wr(1'b0, w);
    rx_dis = rd_off;
    tx_dis = td_off;
    pulse(su_done);
    @(negedge clk);
  endtask
  task automatic s_disable;
    setup_once(16'h0003, 1'b1, 1'b0);
    chk({rxa, txa}, 2'h1);
    pulse(tx_err);
    @(negedge clk);
    chk(txa, 1'b0);
    setup_once(16'h0001, 1'b0, 1'b0);
    chk({rxa, txa}, 2'h3);
    setup_once(16'h0001, 1'b0, 1'b1);
    chk({rxa, txa}, 2'h2);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    {rst, rx_done, tx_done, su_done, rx_dis, tx_dis, tx_err, addr_v, taken} = 9'h100;
    {ready, babble, lost} = 3'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rdchk(16'h0004);
    s_setup_run();
    s_events();
    s_poll();
    s_ready();
    s_timeout();
    s_halt();
    s_disable();
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rdchk(16'h0004);
    summarize();
  end
endmodule
